// ===== pkg/hsi_pkg.sv
// shared constants and types for the host serial interface
package hsi_pkg;
    // strap encodings
    localparam logic       STRAP_BUS_I2C   = 1'b1;
    localparam logic       STRAP_ADDR_SPI  = 1'b1;
    typedef enum logic [2:0] {
        HSI_UART = 3'b001,
        HSI_SPI  = 3'b010,
        HSI_I2C  = 3'b100
    } hsi_mode_e;
    // address byte layout
    localparam int         ADDR_RW_BIT     = 7;
    localparam int         ADDR_HI         = 6;
    localparam int         ADDR_LO         = 1;
    localparam logic       ADDR_RW_READ    = 1'b1;
    localparam logic [7:0] READ_END_BYTE   = 8'h00;
    // device register map and reset values
    localparam logic [5:0] REG_UART_SPEED  = 6'h1F;
    localparam logic [5:0] REG_TEST_PIN_EN = 6'h33;
    localparam int         LINE_EN_BIT     = 7;
    localparam logic [7:0] SPEED_RST       = 8'hEB;
    localparam logic [7:0] TEST_PIN_RST    = 8'h80;
    localparam int         EXP_HI          = 7;
    localparam int         EXP_LO          = 5;
    localparam int         MANT_HI         = 4;
    localparam int         MANT_LO         = 0;
    localparam logic [12:0] MANT_OFS_LOW   = 13'h0001;
    localparam logic [12:0] MANT_OFS_HIGH  = 13'h0021;
    // timing
    localparam int         MCLK_HZ         = 25_000_000;
    localparam int         SPI_MAX_BPS     = 10_000_000;
    localparam int         SCK_HALF_CYC    = (MCLK_HZ + 2 * SPI_MAX_BPS - 1) / (2 * SPI_MAX_BPS);
    localparam int         FIFO_DEPTH      = 16;
    // controller register offsets
    localparam logic [3:0] HREG_ADDR       = 4'h0;
    localparam logic [3:0] HREG_WDATA      = 4'h1;
    localparam logic [3:0] HREG_CTRL       = 4'h2;
    localparam logic [3:0] HREG_STAT       = 4'h3;
    localparam logic [3:0] HREG_RDATA      = 4'h4;
    localparam int         CTRL_GO_BIT     = 0;
    localparam int         CTRL_RD_BIT     = 1;
endpackage

// ===== pkg/hsi_link_if.sv
// link wires between the controller and the device port
`timescale 1ns/10ps
interface hsi_link_if;
    logic chip_select_n;
    logic host_sck;
    logic host_mosi;
    logic shared_pin_7_o;
    logic shared_pin_7_oe;
    logic shared_pin_6_o;
    logic shared_pin_6_oe;
    logic shared_pin_5_o;
    logic shared_pin_5_oe;
    logic shared_pin_7;
    logic shared_pin_6;
    logic shared_pin_5;
    // wire levels; pull-up on the released data line
    assign shared_pin_7 = shared_pin_7_oe ? shared_pin_7_o : 1'b1;
    assign shared_pin_6 = shared_pin_6_oe ? shared_pin_6_o : host_mosi;
    assign shared_pin_5 = shared_pin_5_oe ? shared_pin_5_o : host_sck;
    modport dev (
        input  chip_select_n, shared_pin_6, shared_pin_5,
        output shared_pin_7_o, shared_pin_7_oe, shared_pin_6_o,
        output shared_pin_6_oe, shared_pin_5_o, shared_pin_5_oe
    );
    modport host (
        output chip_select_n, host_sck, host_mosi,
        input  shared_pin_7
    );
endinterface

// ===== src/hsi_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module hsi_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = hsi_pkg::FIFO_DEPTH
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;
    assign o_in_ready  = cnt_q < (AW + 1)'(DEPTH);
    assign o_out_valid = cnt_q != '0;
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// ===== src/hsi_host.sv
// controller end: spi master driven from a small register port
`timescale 1ns/10ps
module hsi_host #(
    parameter int HALF_CYC = hsi_pkg::SCK_HALF_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    hsi_link_if.host        link
);
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
        $error("half period out of range");
    end
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_LEAD = 5'b00010,
        H_HIGH = 5'b00100,
        H_LOW  = 5'b01000,
        H_TAIL = 5'b10000
    } hsi_hstate_e;
    hsi_hstate_e st_q;
    logic [5:0]  reg_addr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rd_out_q;
    logic [15:0] tx_sh_q;
    logic [7:0]  rx_sh_q;
    logic [3:0]  bit_q;
    logic [7:0]  cnt_q;
    logic        cs_n_q;
    logic        sck_q;
    logic        mosi_q;
    logic        half_done;
    logic        go;
    assign half_done = cnt_q == 8'(HALF_CYC - 1);
    assign go = i_wr && i_addr == hsi_pkg::HREG_CTRL && i_wdata[hsi_pkg::CTRL_GO_BIT]
                && st_q == H_IDLE;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            reg_addr_q <= 6'h00;
            wdata_q    <= 8'h00;
        end else if (i_wr && i_addr == hsi_pkg::HREG_ADDR) begin
            reg_addr_q <= i_wdata[5:0];
        end else if (i_wr && i_addr == hsi_pkg::HREG_WDATA) begin
            wdata_q <= i_wdata;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_out_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                hsi_pkg::HREG_ADDR:  rd_out_q <= {2'h0, reg_addr_q};
                hsi_pkg::HREG_WDATA: rd_out_q <= wdata_q;
                hsi_pkg::HREG_STAT:  rd_out_q <= {7'h00, st_q != H_IDLE};
                hsi_pkg::HREG_RDATA: rd_out_q <= rdata_q;
                default:             rd_out_q <= 8'h00;
            endcase
        end else begin
            rd_out_q <= 8'h00;
        end
    end
    // serial engine
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_q    <= H_IDLE;
            cs_n_q  <= 1'b1;
            sck_q   <= 1'b0;
            mosi_q  <= 1'b0;
            tx_sh_q <= 16'h0000;
            rx_sh_q <= 8'h00;
            rdata_q <= 8'h00;
            bit_q   <= 4'h0;
            cnt_q   <= 8'h00;
        end else begin
            cnt_q <= (st_q == H_IDLE || half_done) ? 8'h00 : cnt_q + 8'h01;
            case (st_q)
                H_IDLE: begin
                    if (go) begin
                        tx_sh_q <= {i_wdata[hsi_pkg::CTRL_RD_BIT], reg_addr_q, 1'b0,
                                    i_wdata[hsi_pkg::CTRL_RD_BIT] ? hsi_pkg::READ_END_BYTE
                                                                  : wdata_q};
                        mosi_q  <= i_wdata[hsi_pkg::CTRL_RD_BIT];
                        cs_n_q  <= 1'b0;
                        bit_q   <= 4'h0;
                        st_q    <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (half_done) begin
                        sck_q   <= 1'b1;
                        rx_sh_q <= {rx_sh_q[6:0], link.shared_pin_7};
                        st_q    <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sck_q <= 1'b0;
                        if (bit_q == 4'hF) begin
                            st_q <= H_TAIL;
                        end else begin
                            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                            mosi_q  <= tx_sh_q[14];
                            bit_q   <= bit_q + 4'h1;
                            st_q    <= H_LOW;
                        end
                    end
                end
                H_TAIL: begin
                    if (half_done) begin
                        cs_n_q  <= 1'b1;
                        rdata_q <= rx_sh_q;
                        st_q    <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    assign link.chip_select_n = cs_n_q;
    assign link.host_sck      = sck_q;
    assign link.host_mosi     = mosi_q;
    assign o_rdata            = rd_out_q;
endmodule

// ===== src/hsi_device.sv
// device end: host port with strap detection, spi slave and uart speed
//
// Behaviour
// - re-detect host interface after every reset
// - straps pick uart, spi or i2c
// - shared pins follow selected interface role
// - host generates sck; device only slave
// - all bytes shift msb first
// - host changes mosi after falling edge
// - device updates miso on falling edge
// - read burst returns data one byte later
// - write burst: one address, many data
// - address bit 7 selects read or write
// - address bits 6..1 carry register address
// - uart rate defaults to 9.6 kBd; here the 25 MHz clock / 2816 gives about 8.88 kBd
// - speed register exponent and mantissa set divider
// - line enable clear stops request, aux
// - spi works up to 10 Mbit/s
// - divider is mantissa-based, exponent-scaled
// - host never programs above 1228.8 kBd
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module hsi_device #(
    parameter int DEPTH = hsi_pkg::FIFO_DEPTH
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_bus_type_pin,
    input  wire logic       i_address_select_pin,
    output logic      [2:0] o_mode,
    output logic            o_wr_valid,
    input  wire logic       i_wr_ready,
    output logic      [5:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    output logic            o_baud_tick,
    hsi_link_if.dev         link
);
    if (DEPTH < 2) begin : g_chk
        $error("fifo depth too small");
    end
    logic [7:0]  regs_q [64];
    hsi_pkg::hsi_mode_e mode_q;
    logic        mode_vld_q;
    logic        sck_q;
    logic        rise;
    logic        fall;
    logic        active;
    logic [2:0]  bit_cnt_q;
    logic [6:0]  rx_sh_q;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        first_q;
    logic        read_q;
    logic [5:0]  addr_q;
    logic [7:0]  tx_sh_q;
    logic        miso_q;
    logic        wr_req;
    logic        fifo_in_ready;
    logic [13:0] fifo_out;
    logic [12:0] div_q;
    logic [12:0] baud_cnt_q;
    logic        tick;
    logic        aux_q;

    // divider from the speed register value
    function automatic logic [12:0] baud_div(input logic [7:0] spd);
        logic [2:0]  e;
        logic [12:0] m;
        e = spd[hsi_pkg::EXP_HI:hsi_pkg::EXP_LO];
        m = {8'h00, spd[hsi_pkg::MANT_HI:hsi_pkg::MANT_LO]};
        if (e == 3'h0) begin
            baud_div = m + hsi_pkg::MANT_OFS_LOW;
        end else begin
            baud_div = (m + hsi_pkg::MANT_OFS_HIGH) << (e - 3'h1);
        end
    endfunction

    // register address field of an address byte
    function automatic logic [5:0] addr_of(input logic [7:0] b);
        addr_of = b[hsi_pkg::ADDR_HI:hsi_pkg::ADDR_LO];
    endfunction

    // strap capture one edge after reset release
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mode_vld_q <= 1'b0;
            mode_q     <= hsi_pkg::HSI_I2C;
        end else if (!mode_vld_q) begin
            mode_vld_q <= 1'b1;
            if (i_bus_type_pin == hsi_pkg::STRAP_BUS_I2C) begin
                mode_q <= hsi_pkg::HSI_I2C;
            end else if (i_address_select_pin == hsi_pkg::STRAP_ADDR_SPI) begin
                mode_q <= hsi_pkg::HSI_SPI;
            end else begin
                mode_q <= hsi_pkg::HSI_UART;
            end
        end
    end

    // serial clock edge detection
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= link.shared_pin_5;
        end
    end
    assign active    = mode_vld_q && mode_q == hsi_pkg::HSI_SPI && !link.chip_select_n;
    assign rise      = active && link.shared_pin_5 && !sck_q;
    assign fall      = active && !link.shared_pin_5 && sck_q;
    assign rx_byte   = {rx_sh_q, link.shared_pin_6};
    assign byte_done = rise && bit_cnt_q == 3'h7;
    assign wr_req    = byte_done && !first_q && !read_q;

    // receive side and transaction state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !active) begin
            bit_cnt_q <= 3'h0;
            rx_sh_q   <= 7'h00;
            first_q   <= 1'b1;
            read_q    <= 1'b0;
            addr_q    <= 6'h00;
        end else if (rise) begin
            rx_sh_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                if (first_q) begin
                    first_q <= 1'b0;
                    read_q  <= rx_byte[hsi_pkg::ADDR_RW_BIT] == hsi_pkg::ADDR_RW_READ;
                    addr_q  <= addr_of(rx_byte);
                end else if (read_q) begin
                    addr_q <= addr_of(rx_byte);
                end
            end
        end
    end

    // transmit side
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !active) begin
            tx_sh_q <= 8'h00;
            miso_q  <= 1'b0;
        end else if (byte_done) begin
            if (first_q ? rx_byte[hsi_pkg::ADDR_RW_BIT] == hsi_pkg::ADDR_RW_READ : read_q) begin
                tx_sh_q <= regs_q[addr_of(rx_byte)];
            end else begin
                tx_sh_q <= 8'h00;
            end
        end else if (fall) begin
            miso_q  <= tx_sh_q[7];
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
    end

    // register store; a write lands only when the fifo takes it
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 64; i++) begin
                regs_q[i] <= 8'h00;
            end
            regs_q[hsi_pkg::REG_UART_SPEED]  <= hsi_pkg::SPEED_RST;
            regs_q[hsi_pkg::REG_TEST_PIN_EN] <= hsi_pkg::TEST_PIN_RST;
        end else if (wr_req && fifo_in_ready) begin
            regs_q[addr_q] <= rx_byte;
        end
    end

    hsi_fifo #(
        .WIDTH (14),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (wr_req),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({addr_q, rx_byte}),
        .o_out_valid (o_wr_valid),
        .i_out_ready (i_wr_ready),
        .o_out_data  (fifo_out)
    );
    assign o_wr_addr = fifo_out[13:8];
    assign o_wr_data = fifo_out[7:0];

    // uart baud generator
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            div_q <= baud_div(hsi_pkg::SPEED_RST);
        end else begin
            div_q <= baud_div(regs_q[hsi_pkg::REG_UART_SPEED]);
        end
    end
    assign tick = baud_cnt_q >= div_q - 13'h0001;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            baud_cnt_q <= 13'h0000;
            aux_q      <= 1'b0;
        end else if (tick) begin
            baud_cnt_q <= 13'h0000;
            aux_q      <= !aux_q;
        end else begin
            baud_cnt_q <= baud_cnt_q + 13'h0001;
        end
    end
    assign o_baud_tick = tick && mode_q == hsi_pkg::HSI_UART;

    // shared pin roles
    always_comb begin
        link.shared_pin_7_o  = 1'b1;
        link.shared_pin_7_oe = 1'b0;
        link.shared_pin_6_o  = 1'b0;
        link.shared_pin_6_oe = 1'b0;
        link.shared_pin_5_o  = 1'b0;
        link.shared_pin_5_oe = 1'b0;
        if (mode_vld_q) begin
            case (mode_q)
                hsi_pkg::HSI_SPI: begin
                    link.shared_pin_7_o  = miso_q;
                    link.shared_pin_7_oe = !link.chip_select_n;
                end
                hsi_pkg::HSI_UART: begin
                    link.shared_pin_7_oe = 1'b1;
                    link.shared_pin_6_o  = aux_q;
                    link.shared_pin_6_oe = regs_q[hsi_pkg::REG_TEST_PIN_EN][hsi_pkg::LINE_EN_BIT];
                    link.shared_pin_5_o  = o_wr_valid;
                    link.shared_pin_5_oe = regs_q[hsi_pkg::REG_TEST_PIN_EN][hsi_pkg::LINE_EN_BIT];
                end
                default: begin
                    link.shared_pin_7_oe = 1'b0;
                end
            endcase
        end
    end
    assign o_mode = mode_q;
endmodule

// ===== tb/hsi_chk.sv
// concurrent checks on the link wires between controller and device
`timescale 1ns/10ps
module hsi_chk (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic chip_select_n,
    input wire logic host_sck,
    input wire logic host_mosi,
    input wire logic shared_pin_7_o,
    input wire logic shared_pin_7_oe,
    input wire logic shared_pin_6_oe,
    input wire logic shared_pin_5_oe
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    logic       sck_q;
    logic [4:0] rise_cnt_q;

    // sck rising edges seen within the current frame
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sck_q      <= 1'b0;
            rise_cnt_q <= 5'h00;
        end else begin
            sck_q <= host_sck;
            if (chip_select_n) begin
                rise_cnt_q <= 5'h00;
            end else if (host_sck && !sck_q) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    chk_mosi_stable: assert property (host_sck |-> $stable(host_mosi))
        else $error("mosi moved while sck high");
    chk_sck_idle: assert property (chip_select_n |-> !host_sck)
        else $error("sck high outside a frame");
    chk_sck_high_min: assert property ($rose(host_sck) |=> host_sck)
        else $error("sck high phase too short");
    chk_sck_low_min: assert property ($fell(host_sck) |=> !host_sck)
        else $error("sck low phase too short");
    chk_frame_bits: assert property ($rose(chip_select_n) |-> rise_cnt_q == 5'h10)
        else $error("frame did not carry 16 clocks");
    chk_miso_on_fall: assert property ((shared_pin_7_oe && $past(shared_pin_7_oe)
        && $changed(shared_pin_7_o)) |-> ($past(host_sck, 2) && !$past(host_sck)))
        else $error("miso changed away from a falling sck");
    chk_miso_drive: assert property ($fell(chip_select_n) |-> ##[0:2] shared_pin_7_oe)
        else $error("miso not driven in frame");
    chk_miso_release: assert property ((chip_select_n && $past(chip_select_n)
        && !shared_pin_6_oe) |-> !shared_pin_7_oe)
        else $error("miso driven while deselected");
    chk_slave_inputs: assert property (!chip_select_n
        |-> (!shared_pin_5_oe && !shared_pin_6_oe))
        else $error("device drove sck or mosi");

    cov_frame_end: cover property ($rose(chip_select_n));
    cov_miso_on: cover property ($rose(shared_pin_7_oe));
    cov_uart_pins: cover property (shared_pin_6_oe && shared_pin_5_oe);
endmodule

// ===== tb/testbench.sv
// self-checking bench for the controller and device pair
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
    logic        i_mclk;
    logic        i_rst_n;
    logic        bus_type;
    logic        addr_sel;
    logic        wr_ready;
    logic [3:0]  h_addr;
    logic [7:0]  h_wdata;
    logic [7:0]  h_rdata;
    logic        h_wr;
    logic        h_rd;
    logic [2:0]  mode;
    logic        wr_valid;
    logic        baud_tick;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [15:0] mosi_sr;
    logic [15:0] miso_sr;
    logic [7:0]  q;
    int          mismatches;
    int          cmp_count;

    hsi_link_if link ();
    hsi_host u_hsi_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(h_addr),
        .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata), .link(link.host));
    hsi_device u_hsi_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_type_pin(bus_type),
        .i_address_select_pin(addr_sel), .o_mode(mode), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_baud_tick(baud_tick), .link(link.dev));
    hsi_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .chip_select_n(link.chip_select_n),
        .host_sck(link.host_sck), .host_mosi(link.host_mosi),
        .shared_pin_7_o(link.shared_pin_7_o), .shared_pin_7_oe(link.shared_pin_7_oe),
        .shared_pin_6_oe(link.shared_pin_6_oe), .shared_pin_5_oe(link.shared_pin_5_oe));

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    // wire capture at each sck rise
    always @(posedge link.host_sck) begin
        mosi_sr <= {mosi_sr[14:0], link.shared_pin_6};
        miso_sr <= {miso_sr[14:0], link.shared_pin_7};
    end

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic hwr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        h_addr  <= a;
        h_wdata <= d;
        h_wr    <= 1'b1;
        @(posedge i_mclk);
        h_wr <= 1'b0;
    endtask

    task automatic hrd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        h_addr <= a;
        h_rd   <= 1'b1;
        @(posedge i_mclk);
        h_rd <= 1'b0;
        #1;
        d = h_rdata;
    endtask

    task automatic frame(input logic rd, input logic [5:0] a, input logic [7:0] d,
                         output logic [7:0] r);
        logic [7:0] s;
        hwr(hsi_pkg::HREG_ADDR, {2'h0, a});
        hwr(hsi_pkg::HREG_WDATA, d);
        hwr(hsi_pkg::HREG_CTRL, {6'h00, rd, 1'b1});
        repeat (4) @(posedge i_mclk);
        for (int k = 0; k < 100; k++) begin
            hrd(hsi_pkg::HREG_STAT, s);
            if (s[0] === 1'b0) break;
        end
        `CHK("busy", 1'b0, s[0])
        `CHK("mosi_frame", {rd, a, 1'b0, (rd ? 8'h00 : d)}, mosi_sr)
        hrd(hsi_pkg::HREG_RDATA, r);
    endtask

    task automatic pop();
        @(posedge i_mclk);
        wr_ready <= 1'b1;
        @(posedge i_mclk);
        wr_ready <= 1'b0;
        #1;
    endtask

    task automatic do_reset(input logic bt, input logic as);
        @(posedge i_mclk);
        i_rst_n  <= 1'b0;
        bus_type <= bt;
        addr_sel <= as;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask

    task automatic t_modes();
        int n;
        do_reset(1'b0, 1'b0);
        `CHK("mode_uart", hsi_pkg::HSI_UART, mode)
        `CHK("uart_pins_oe", 3'b111, {link.shared_pin_7_oe, link.shared_pin_6_oe,
            link.shared_pin_5_oe})
        n = 0;
        while (baud_tick !== 1'b1 && n < 4000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
        end while (baud_tick !== 1'b1 && n < 4000);
        // speed eb: (11 + 33) * 2**6 cycles
        `CHK("baud_period", 2816, n)
        do_reset(1'b1, 1'b0);
        `CHK("mode_i2c", hsi_pkg::HSI_I2C, mode)
        `CHK("i2c_pins_oe", 3'b000, {link.shared_pin_7_oe, link.shared_pin_6_oe,
            link.shared_pin_5_oe})
        do_reset(1'b0, 1'b1);
        `CHK("mode_spi", hsi_pkg::HSI_SPI, mode)
        `CHK("spi_idle_oe", 3'b000, {link.shared_pin_7_oe, link.shared_pin_6_oe,
            link.shared_pin_5_oe})
    endtask

    task automatic t_write_read();
        logic [5:0] aa [2];
        logic [7:0] dd [2];
        aa = '{6'h05, 6'h3E};
        dd = '{8'hA5, 8'h5A};
        for (int i = 0; i < 2; i++) begin
            frame(1'b0, aa[i], dd[i], q);
            `CHK("wr_valid", 1'b1, wr_valid)
            `CHK("wr_addr", aa[i], wr_addr)
            `CHK("wr_data", dd[i], wr_data)
            pop();
            `CHK("wr_empty", 1'b0, wr_valid)
            frame(1'b1, aa[i], 8'h00, q);
            `CHK("rd_data", dd[i], q)
            `CHK("miso_byte", dd[i], miso_sr[7:0])
        end
    endtask

    task automatic t_regs();
        frame(1'b1, hsi_pkg::REG_UART_SPEED, 8'h00, q);
        `CHK("speed_rst", 8'hEB, q)
        frame(1'b1, hsi_pkg::REG_TEST_PIN_EN, 8'h00, q);
        `CHK("pin_en_rst", 8'h80, q)
        frame(1'b0, hsi_pkg::REG_UART_SPEED, 8'h3A, q);
        pop();
        frame(1'b1, hsi_pkg::REG_UART_SPEED, 8'h00, q);
        `CHK("speed_wr", 8'h3A, q)
        frame(1'b0, hsi_pkg::REG_TEST_PIN_EN, 8'h00, q);
        pop();
        frame(1'b1, hsi_pkg::REG_TEST_PIN_EN, 8'h00, q);
        `CHK("line_en_clr", 8'h00, q)
    endtask

    task automatic t_fifo_full();
        for (int i = 0; i < 17; i++) begin
            frame(1'b0, 6'h20 + 6'(i), 8'hC0 + 8'(i), q);
        end
        for (int i = 0; i < 16; i++) begin
            `CHK("fifo_valid", 1'b1, wr_valid)
            `CHK("fifo_addr", 6'h20 + 6'(i), wr_addr)
            `CHK("fifo_data", 8'hC0 + 8'(i), wr_data)
            pop();
        end
        `CHK("fifo_drained", 1'b0, wr_valid)
        frame(1'b1, 6'h2F, 8'h00, q);
        `CHK("last_kept", 8'hCF, q)
        frame(1'b1, 6'h30, 8'h00, q);
        `CHK("overflow_dropped", 8'h00, q)
    endtask

    task automatic t_unmapped();
        hwr(4'hF, 8'hFF);
        hrd(4'hF, q);
        `CHK("unmapped_rd", 8'h00, q)
        hrd(hsi_pkg::HREG_ADDR, q);
        `CHK("addr_rd", 8'h30, q)
        @(posedge i_mclk);
        #1;
        `CHK("rdata_one_cycle", 8'h00, h_rdata)
    endtask

    initial begin
        i_rst_n    = 1'b0;
        bus_type   = 1'b0;
        addr_sel   = 1'b1;
        wr_ready   = 1'b0;
        h_addr     = 4'h0;
        h_wdata    = 8'h00;
        h_wr       = 1'b0;
        h_rd       = 1'b0;
        mismatches = 0;
        cmp_count  = 0;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_modes();
        t_write_read();
        t_regs();
        t_fifo_full();
        t_unmapped();
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        mismatches++;
        give_verdict();
    end
endmodule
